// file: timer_capture_compare_pair.sv
//
// Behaviour
// - first trigger edge code: 00 falling, 01 rising, 11 both, 10 prohibited
// - first register from first trigger captures opposite edge; none when both
// - second trigger edge code same; first register captures on that same edge
// - second register in capture role uses only first trigger, same edge
// - control bit 2 picks capture or compare role of second register
// - second register in compare role raises second match request on equality
// - registers writable in compare role, read-only in capture role
// - reset clears both capture/compare registers to zero
// - first register zero in free or edge-clear mode matches at wrap
// - second register zero in free or edge-clear mode matches at wrap
// - reset clears mode control register to zero
// - mode control takes single-bit writes as well as whole writes
// - counter runs while mode bits not both zero; zeros stop it
// - mode bits zero: counter held at zero, no match requests
// - control bit 0 picks capture or compare role of first register
// - first register in compare role raises first match request on equality
// - edge selection fields live in the prescale edge register
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "tcc_defines.svh"
module timer_capture_compare_pair (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // register port
    input  tcc_pkg::bus_req_t       req_i,
    output logic [15:0]             rdata_o,
    // count rate enable from the prescaler
    input  wire logic               count_en_i,
    // trigger pins
    input  wire logic               trigger_input_first_i,
    input  wire logic               trigger_input_second_i,
    // match requests
    output logic                    match_irq_first_o,
    output logic                    match_irq_second_o
);
    import tcc_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic valid_edge(input edge_sel_t sel, input edge_ev_t ev);
        case (sel)
            EDGE_FALL: valid_edge = ev.fall;
            EDGE_RISE: valid_edge = ev.rise;
            EDGE_BOTH: valid_edge = ev.rise | ev.fall;
            default:   valid_edge = 1'b0;
        endcase
    endfunction

    function automatic logic opposite_edge(input edge_sel_t sel, input edge_ev_t ev);
        case (sel)
            EDGE_FALL: opposite_edge = ev.rise;
            EDGE_RISE: opposite_edge = ev.fall;
            default:   opposite_edge = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // state and wiring
    // ------------------------------------------------------------------
    core_state_t        q;
    core_state_t        next_q;

    logic [1:0]         pins;
    edge_ev_t           ev [2];
    edge_sel_t          es_first;
    edge_sel_t          es_second;
    op_mode_t           mode;
    logic               run;
    logic               valid_first;
    logic               clr_edge;
    logic               tick;
    logic [DATA_W:0]    inc;

    logic [1:0]         role_capture;
    logic [1:0]         capture;
    logic [1:0]         wr_cc;
    logic [1:0]         hit;
    logic [1:0]         match;
    logic [DATA_W-1:0]  cc_value [2];

    assign pins = {trigger_input_second_i, trigger_input_first_i};

    // ------------------------------------------------------------------
    // trigger synchronisers and edge detectors
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_trig
        trig_edge u_trig (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .pin_i (pins[i]),
            .ev_o  (ev[i])
        );
    end

    // ------------------------------------------------------------------
    // mode and trigger decode
    // ------------------------------------------------------------------
    assign es_first  = edge_sel_t'(q.prm[`TCC_PRM_ES_FIRST +: 2]);
    assign es_second = edge_sel_t'(q.prm[`TCC_PRM_ES_SECOND +: 2]);
    assign mode      = op_mode_t'(q.tmc[`TCC_TMC_MODE_LSB +: 2]);

    assign run         = (mode != MODE_STOP);
    assign valid_first = valid_edge(es_first, ev[0]);
    assign clr_edge    = run && (mode == MODE_CLR_EDGE) && valid_first;
    // an edge clear replaces the count step, so no compare on that cycle
    assign tick        = run && count_en_i && !clr_edge;
    assign inc         = {1'b0, q.cnt} + {{DATA_W{1'b0}}, 1'b1};

    assign role_capture[0] = q.crc[`TCC_CRC_ROLE_FIRST];
    assign role_capture[1] = q.crc[`TCC_CRC_ROLE_SECOND];

    always_comb
    begin
        if (q.crc[`TCC_CRC_SRC_FIRST])
            capture[0] = valid_edge(es_second, ev[1]);
        else
            capture[0] = opposite_edge(es_first, ev[0]);
    end

    assign capture[1] = valid_first;

    assign wr_cc[0] = req_i.wr && (req_i.addr == `TCC_ADDR_CC_FIRST);
    assign wr_cc[1] = req_i.wr && (req_i.addr == `TCC_ADDR_CC_SECOND);

    // ------------------------------------------------------------------
    // capture/compare registers
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_cc
        cc_reg #(
            .W (DATA_W)
        ) u_cc (
            .clk_i          (clk_i),
            .rst_i          (rst_i),
            .capture_role_i (role_capture[i]),
            .capture_i      (capture[i]),
            .wr_i           (wr_cc[i]),
            .wdata_i        (req_i.wdata),
            .tick_i         (tick),
            .count_i        (q.cnt),
            .next_count_i   (inc[DATA_W-1:0]),
            .hit_o          (hit[i]),
            .value_o        (cc_value[i]),
            .match_o        (match[i])
        );
    end

    assign match_irq_first_o  = match[0];
    assign match_irq_second_o = match[1];

    // ------------------------------------------------------------------
    // counter, registers and read port
    // ------------------------------------------------------------------
    always_comb
    begin
        next_q       = q;
        next_q.rdata = '0;

        if (req_i.wr)
        begin
            case (req_i.addr)
                `TCC_ADDR_TMC:     next_q.tmc = req_i.wdata[3:0];
                `TCC_ADDR_TMC_SET: next_q.tmc = q.tmc | req_i.wdata[3:0];
                `TCC_ADDR_TMC_CLR: next_q.tmc = q.tmc & ~req_i.wdata[3:0];
                `TCC_ADDR_CRC:     next_q.crc = req_i.wdata[2:0];
                `TCC_ADDR_PRM:     next_q.prm = req_i.wdata[3:0];
                default:           next_q.tmc = next_q.tmc;
            endcase
        end

        if (!run)
            next_q.cnt = '0;
        else if (clr_edge)
            next_q.cnt = '0;
        else if (tick)
        begin
            if (mode == MODE_CLR_MATCH && hit[0])
                next_q.cnt = '0;
            else
                next_q.cnt = inc[DATA_W-1:0];
        end

        // overflow set wins over a clearing write in the same cycle
        if (tick && inc[DATA_W])
            next_q.tmc[`TCC_TMC_OVF_BIT] = 1'b1;

        if (req_i.rd)
        begin
            case (req_i.addr)
                `TCC_ADDR_CC_FIRST:  next_q.rdata = cc_value[0];
                `TCC_ADDR_CC_SECOND: next_q.rdata = cc_value[1];
                `TCC_ADDR_TMC:       next_q.rdata = DATA_W'(q.tmc);
                `TCC_ADDR_CRC:       next_q.rdata = DATA_W'(q.crc);
                `TCC_ADDR_PRM:       next_q.rdata = DATA_W'(q.prm);
                `TCC_ADDR_COUNT:     next_q.rdata = q.cnt;
                default:             next_q.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q.cnt   <= '0;
            q.tmc   <= `TCC_TMC_RESET;
            q.crc   <= `TCC_CRC_RESET;
            q.prm   <= `TCC_PRM_RESET;
            q.rdata <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign rdata_o = q.rdata;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_first_decode;
        (es_first == EDGE_RISE && ev[0].rise) ||
        (es_first == EDGE_FALL && ev[0].fall) ||
        (es_first == EDGE_BOTH && (ev[0].rise || ev[0].fall)) |-> valid_first;
    endproperty
    a_first_decode: assert property (p_first_decode)
        else $error("valid edge of first trigger not decoded");

    property p_prohibited;
        (es_first == EDGE_NONE) |-> !valid_first && !capture[1];
    endproperty
    a_prohibited: assert property (p_prohibited)
        else $error("prohibited edge code produced an edge");

    sequence s_first_opp_edge;
        role_capture[0] && !q.crc[`TCC_CRC_SRC_FIRST] &&
        es_first == EDGE_RISE && ev[0].fall;
    endsequence

    property p_capture_opposite;
        s_first_opp_edge |=> cc_value[0] == $past(q.cnt);
    endproperty
    a_capture_opposite: assert property (p_capture_opposite)
        else $error("first register missed opposite-edge capture");

    property p_no_capture_both;
        (role_capture[0] && !q.crc[`TCC_CRC_SRC_FIRST] && es_first == EDGE_BOTH)
            |=> $stable(cc_value[0]);
    endproperty
    a_no_capture_both: assert property (p_no_capture_both)
        else $error("first register captured with both edges selected");

    property p_capture_second_src;
        (role_capture[0] && q.crc[`TCC_CRC_SRC_FIRST] &&
         es_second == EDGE_FALL && ev[1].fall) |=> cc_value[0] == $past(q.cnt);
    endproperty
    a_capture_second_src: assert property (p_capture_second_src)
        else $error("first register missed second-trigger capture");

    property p_capture_second_reg;
        (role_capture[1] && valid_first) |=> cc_value[1] == $past(q.cnt);
    endproperty
    a_capture_second_reg: assert property (p_capture_second_reg)
        else $error("second register missed capture");

    property p_match_second;
        (tick && !role_capture[1] && inc[DATA_W-1:0] == cc_value[1])
            |=> match_irq_second_o;
    endproperty
    a_match_second: assert property (p_match_second)
        else $error("second match request missing");

    property p_match_first;
        (tick && !role_capture[0] && inc[DATA_W-1:0] == cc_value[0])
            |=> match_irq_first_o;
    endproperty
    a_match_first: assert property (p_match_first)
        else $error("first match request missing");

    property p_clear_match;
        (mode == MODE_CLR_MATCH && tick && hit[0]) |=>
            q.cnt == 16'h0000 && match_irq_first_o;
    endproperty
    a_clear_match: assert property (p_clear_match)
        else $error("clear-on-match cycle did not restart");

    sequence s_wrap_zero(int idx);
        mode == MODE_FREE && tick && q.cnt == 16'hFFFF &&
        !role_capture[idx] && cc_value[idx] == 16'h0000;
    endsequence

    property p_wrap_first;
        s_wrap_zero(0) |=> match_irq_first_o && q.cnt == 16'h0000;
    endproperty
    a_wrap_first: assert property (p_wrap_first)
        else $error("zero first register missed wrap match");

    property p_wrap_second;
        s_wrap_zero(1) |=> match_irq_second_o;
    endproperty
    a_wrap_second: assert property (p_wrap_second)
        else $error("zero second register missed wrap match");

    property p_stopped;
        (mode == MODE_STOP) |=> q.cnt == 16'h0000 &&
            !match_irq_first_o && !match_irq_second_o;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("stopped counter moved or requested");

    property p_running;
        (mode == MODE_FREE && count_en_i) |=>
            q.cnt == DATA_W'($past(q.cnt) + 16'h0001);
    endproperty
    a_running: assert property (p_running)
        else $error("running counter did not step");

    property p_bit_set;
        (req_i.wr && req_i.addr == `TCC_ADDR_TMC_SET) |=>
            ((q.tmc & $past(req_i.wdata[3:0])) == $past(req_i.wdata[3:0]));
    endproperty
    a_bit_set: assert property (p_bit_set)
        else $error("single-bit set of mode control lost");

    property p_reset_values;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> q.tmc == 4'h0 && cc_value[0] == 16'h0000 &&
            cc_value[1] == 16'h0000;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

endmodule // timer_capture_compare_pair

// file: tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ------------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------------
`define TCC_ADDR_CC_FIRST   3'h0
`define TCC_ADDR_CC_SECOND  3'h1
`define TCC_ADDR_TMC        3'h2
`define TCC_ADDR_CRC        3'h3
`define TCC_ADDR_PRM        3'h4
`define TCC_ADDR_COUNT      3'h5
`define TCC_ADDR_TMC_SET    3'h6
`define TCC_ADDR_TMC_CLR    3'h7

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define TCC_TMC_OVF_BIT     0
`define TCC_TMC_MODE_LSB    2
`define TCC_CRC_ROLE_FIRST  0
`define TCC_CRC_SRC_FIRST   1
`define TCC_CRC_ROLE_SECOND 2
`define TCC_PRM_ES_FIRST    0
`define TCC_PRM_ES_SECOND   2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define TCC_CC_RESET        16'h0000
`define TCC_TMC_RESET       4'h0
`define TCC_CRC_RESET       3'h0
`define TCC_PRM_RESET       4'h0

`endif

// file: tcc_pkg.sv
package tcc_pkg;

    localparam int DATA_W = 16;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;

    typedef enum logic [1:0] {
        MODE_STOP      = 2'h0,
        MODE_FREE      = 2'h1,
        MODE_CLR_EDGE  = 2'h2,
        MODE_CLR_MATCH = 2'h3
    } op_mode_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_ev_t;

    typedef struct packed {
        logic [2:0]        addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic     s1;
        logic     s2;
        logic     prev;
        edge_ev_t ev;
    } trig_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] cnt;
        logic [3:0]        tmc;
        logic [2:0]        crc;
        logic [3:0]        prm;
        logic [DATA_W-1:0] rdata;
    } core_state_t;

endpackage

// file: trig_edge.sv
`timescale 1ns/1ps
module trig_edge (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // pin side
    input  wire logic         pin_i,
    // event side
    output tcc_pkg::edge_ev_t ev_o
);
    import tcc_pkg::*;

    trig_state_t q;
    trig_state_t next_q;

    // two-stage sync, then edge detect on the second stage only
    always_comb
    begin
        next_q         = q;
        next_q.s1      = pin_i;
        next_q.s2      = q.s1;
        next_q.prev    = q.s2;
        next_q.ev.rise = q.s2 & ~q.prev;
        next_q.ev.fall = ~q.s2 & q.prev;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign ev_o = q.ev;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rise_seen;
        $rose(q.s2) |=> ev_o.rise && !ev_o.fall;
    endproperty
    a_rise_seen: assert property (p_rise_seen)
        else $error("synchronised rise not reported");

endmodule // trig_edge

// file: cc_reg.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
module cc_reg #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         capture_role_i,
    input  wire logic         capture_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    // counter side
    input  wire logic         tick_i,
    input  wire logic [W-1:0] count_i,
    input  wire logic [W-1:0] next_count_i,
    // results
    output logic              hit_o,
    output logic [W-1:0]      value_o,
    output logic              match_o
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [W-1:0] value;
        logic         match;
    } cc_state_t;

    cc_state_t q;
    cc_state_t next_q;

    if (W < 2 || W > 32)
    begin : g_bad_width
        $error("cc_reg width out of range");
    end

    // compare against the value the counter is about to take
    assign hit_o = !capture_role_i && tick_i && (next_count_i == q.value);

    always_comb
    begin
        next_q       = q;
        next_q.match = hit_o;
        if (capture_role_i && capture_i)
            next_q.value = count_i;
        else if (!capture_role_i && wr_i)
            next_q.value = wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q <= '{value: W'(`TCC_CC_RESET), match: 1'b0};
        else
            q <= next_q;
    end

    assign value_o = q.value;
    assign match_o = q.match;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_capture_ro;
        (capture_role_i && wr_i && !capture_i) |=> $stable(value_o);
    endproperty
    a_capture_ro: assert property (p_capture_ro)
        else $error("software write changed a capture register");

    property p_compare_rw;
        (!capture_role_i && wr_i) |=> value_o == $past(wdata_i);
    endproperty
    a_compare_rw: assert property (p_compare_rw)
        else $error("software write lost on a compare register");

endmodule // cc_reg

// file: trig_pin_model.sv
`timescale 1ns/1ps
module trig_pin_model (
    // clock
    input  wire logic clk_i,
    // trigger pins
    output logic      first_o,
    output logic      second_o
);
    initial
    begin
        first_o  = 1'b0;
        second_o = 1'b0;
    end

    // one level change, then quiet long enough for the capture to settle
    task automatic drive(input bit sel, input logic lvl);
        @(posedge clk_i);
        if (sel)
            second_o <= lvl;
        else
            first_o <= lvl;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // trig_pin_model

// file: tb_timer_capture_compare_pair.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tb_timer_capture_compare_pair;
    import tcc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    bus_req_t    req;
    logic [15:0] rdata;
    logic        count_en_i;
    wire         trig_first;
    wire         trig_second;
    logic        irq_first;
    logic        irq_second;
    int          miscompares;
    int          n_compared;
    int          cycles;

    timer_capture_compare_pair uut (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .req_i                  (req),
        .rdata_o                (rdata),
        .count_en_i             (count_en_i),
        .trigger_input_first_i  (trig_first),
        .trigger_input_second_i (trig_second),
        .match_irq_first_o      (irq_first),
        .match_irq_second_o     (irq_second)
    );

    trig_pin_model pins (
        .clk_i    (clk_i),
        .first_o  (trig_first),
        .second_o (trig_second)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // whole 16-bit word per access
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask

    task automatic tick();
        @(posedge clk_i);
        count_en_i <= 1'b1;
        @(posedge clk_i);
        count_en_i <= 1'b0;
        #1;
    endtask

    // does an edge of this direction capture, for edge code c
    function automatic bit cap_on(int c, bit rise, bit opp);
        if (opp)
            return rise ? (c == 0) : (c == 1);
        return rise ? (c == 1 || c == 3) : (c == 0 || c == 3);
    endfunction

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int          h1;
        int          h2;
        logic [15:0] e1;
        logic [15:0] e2;
        logic [15:0] k;
        miscompares = 0;
        n_compared  = 0;
        cycles      = 0;
        req         = '0;
        count_en_i  = 1'b0;
        rst_i       = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;

        rd_chk(`TCC_ADDR_CC_FIRST, 16'h0000);
        rd_chk(`TCC_ADDR_CC_SECOND, 16'h0000);
        rd_chk(`TCC_ADDR_TMC, 16'h0000);
        rd_chk(`TCC_ADDR_COUNT, 16'h0000);
        $display("test reset values done");

        wr(`TCC_ADDR_TMC_SET, 16'h000C);
        rd_chk(`TCC_ADDR_TMC, 16'h000C);
        wr(`TCC_ADDR_TMC_CLR, 16'h0008);
        rd_chk(`TCC_ADDR_TMC, 16'h0004);
        wr(`TCC_ADDR_TMC_CLR, 16'h0004);
        h1 = 0;
        repeat (3)
        begin
            tick();
            if (irq_first !== 1'b0 || irq_second !== 1'b0)
                h1++;
        end
        chk(h1, 0);
        rd_chk(`TCC_ADDR_COUNT, 16'h0000);
        wr(`TCC_ADDR_TMC_SET, 16'h0004);
        tick();
        tick();
        rd_chk(`TCC_ADDR_COUNT, 16'h0002);
        wr(`TCC_ADDR_TMC_CLR, 16'h0004);
        rd_chk(`TCC_ADDR_COUNT, 16'h0000);
        $display("test mode control done");

        wr(`TCC_ADDR_CC_FIRST, 16'h0003);
        wr(`TCC_ADDR_CC_SECOND, 16'h0005);
        rd_chk(`TCC_ADDR_CC_FIRST, 16'h0003);
        rd_chk(`TCC_ADDR_CC_SECOND, 16'h0005);
        wr(`TCC_ADDR_TMC_SET, 16'h0004);
        h1 = 0;
        h2 = 0;
        for (int i = 1; i <= 6; i++)
        begin
            tick();
            if (irq_first === 1'b1)
                h1 = i;
            if (irq_second === 1'b1)
                h2 = i;
        end
        chk(h1, 3);
        chk(h2, 5);
        $display("test compare done");

        // clear-on-match with nonzero registers, then clear on first trigger edge
        wr(`TCC_ADDR_TMC_CLR, 16'h000C);
        wr(`TCC_ADDR_TMC_SET, 16'h000C);
        h1 = 0;
        h2 = 0;
        repeat (6)
        begin
            tick();
            h1 += (irq_first === 1'b1);
            h2 += (irq_second === 1'b1);
        end
        chk(h1, 2);
        chk(h2, 0);
        rd_chk(`TCC_ADDR_COUNT, 16'h0000);
        wr(`TCC_ADDR_TMC_CLR, 16'h0004);
        wr(`TCC_ADDR_PRM, 16'h0001);
        tick();
        tick();
        rd_chk(`TCC_ADDR_COUNT, 16'h0002);
        pins.drive(1'b0, 1'b1);
        rd_chk(`TCC_ADDR_COUNT, 16'h0000);
        pins.drive(1'b0, 1'b0);
        wr(`TCC_ADDR_TMC_CLR, 16'h0008);
        wr(`TCC_ADDR_TMC_SET, 16'h0004);
        $display("test clear modes done");

        // both registers in capture role, first fed by the first pin
        wr(`TCC_ADDR_CRC, 16'h0005);
        e1 = 16'h0003;
        e2 = 16'h0005;
        k  = 16'h0000;
        for (int c = 0; c < 4; c++)
        begin
            wr(`TCC_ADDR_PRM, 16'(c));
            rd_chk(`TCC_ADDR_PRM, 16'(c));
            for (int r = 1; r >= 0; r--)
            begin
                tick();
                k++;
                pins.drive(1'b0, r[0]);
                if (cap_on(c, r[0], 1'b1))
                    e1 = k;
                if (cap_on(c, r[0], 1'b0))
                    e2 = k;
                rd_chk(`TCC_ADDR_CC_FIRST, e1);
                rd_chk(`TCC_ADDR_CC_SECOND, e2);
            end
        end
        wr(`TCC_ADDR_CC_FIRST, 16'hABCD);
        rd_chk(`TCC_ADDR_CC_FIRST, e1);
        wr(`TCC_ADDR_CRC, 16'h0007);
        for (int c = 0; c < 4; c++)
        begin
            wr(`TCC_ADDR_PRM, 16'(c << 2));
            for (int r = 1; r >= 0; r--)
            begin
                tick();
                k++;
                pins.drive(1'b1, r[0]);
                if (cap_on(c, r[0], 1'b0))
                    e1 = k;
                rd_chk(`TCC_ADDR_CC_FIRST, e1);
                rd_chk(`TCC_ADDR_CC_SECOND, e2);
            end
        end
        $display("test capture done");

        wr(`TCC_ADDR_CRC, 16'h0000);
        wr(`TCC_ADDR_CC_FIRST, 16'h0000);
        wr(`TCC_ADDR_CC_SECOND, 16'h0000);
        wr(`TCC_ADDR_TMC_CLR, 16'h000C);
        @(posedge clk_i);
        count_en_i <= 1'b1;
        wr(`TCC_ADDR_TMC_SET, 16'h0004);
        h1 = 0;
        h2 = 0;
        for (int n = 1; n <= 70000 && (h1 == 0 || h2 == 0); n++)
        begin
            @(posedge clk_i);
            #1;
            if (irq_first === 1'b1 && h1 == 0)
                h1 = n;
            if (irq_second === 1'b1 && h2 == 0)
                h2 = n;
        end
        chk(h1, 65536);
        chk(h2, 65536);
        rd_chk(`TCC_ADDR_TMC, 16'h0005);
        $display("test zero compare wrap done");
        complete_run();
    end
endmodule // tb_timer_capture_compare_pair
